// ===== verilog/ccs_pkg.sv
/*
  Constants for the charge cycle sequencer: phase codes, default targets,
  safety and top-off timer lengths, APB register map and field positions.
  Assumes a 40 MHz system clock and a 1 s timebase derived from it.
*/
`default_nettype none
package ccs_pkg;
  // Clock and timebase
  localparam int unsigned CLK_HZ        = 40000000;
  localparam int unsigned TICK_S        = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_S;
  // Safety timer lengths in hours and top-off step in minutes, converted to seconds
  localparam int unsigned TRICKLE_TMR_H = 1;
  localparam int unsigned PRECHG_TMR_H  = 2;
  localparam int unsigned FAST_TMR_H    = 12;
  localparam int unsigned SEC_PER_H     = 3600;
  localparam int unsigned TRICKLE_TICKS = TRICKLE_TMR_H * SEC_PER_H;
  localparam int unsigned PRECHG_TICKS  = PRECHG_TMR_H * SEC_PER_H;
  localparam int unsigned FAST_TICKS    = FAST_TMR_H * SEC_PER_H;
  localparam int unsigned TOPOFF_MIN    = 15;
  localparam int unsigned TOPOFF_STEP_S = TOPOFF_MIN * 60;
  // Charge phase codes
  localparam logic [2:0] PH_IDLE    = 3'h0;
  localparam logic [2:0] PH_TRICKLE = 3'h1;
  localparam logic [2:0] PH_PRECHG  = 3'h2;
  localparam logic [2:0] PH_CC      = 3'h3;
  localparam logic [2:0] PH_CV      = 3'h4;
  localparam logic [2:0] PH_TOPOFF  = 3'h6;
  localparam logic [2:0] PH_DONE    = 3'h7;
  // Voltages in mV, plus the reset value of the recharge offset select
  localparam logic [15:0] CELL_CHARGE_VOLTAGE_TARGET_MV   = 16'h1068;
  localparam logic [15:0] TRICKLE_EXIT_MV = 16'h0898;
  localparam logic [15:0] RECHG_BASE_MV  = 16'h00C8;
  localparam logic [15:0] RECHG_STEP_MV  = 16'h0064;
  localparam logic [1:0]  RECHG_SEL_RST  = 2'h1;
  // Currents in mA
  localparam logic [15:0] TRICKLE_MA     = 16'h0064;
  localparam logic [15:0] PRECHG_MA      = 16'h0078;
  localparam logic [15:0] FAST_LO_MA     = 16'h07D0;
  localparam logic [15:0] FAST_HI_MA     = 16'h03E8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CHARGE_VOLTAGE_TARGET   = 8'h08;
  localparam logic [7:0] REG_FAST_CHARGE_CURRENT   = 8'h0C;
  // Control field positions and control register reset value
  localparam int unsigned CTL_CHG_EN   = 0;
  localparam int unsigned CTL_TERM_EN  = 1;
  localparam int unsigned CTL_STAT_DIS = 2;
  localparam int unsigned CTL_LDO_DIS  = 3;
  localparam int unsigned CTL_MASK     = 4;
  localparam int unsigned CTL_RST      = 5;
  localparam int unsigned CTL_RECHG    = 6;
  localparam int unsigned CTL_TOPOFF   = 8;
  localparam logic [9:0]  CTL_RESET    = 10'h043;
  // Status blink half period in timebase ticks
  localparam int unsigned BLINK_TICKS  = 1;
endpackage : ccs_pkg
`default_nettype wire

// ===== verilog/ccs_sequencer.sv
/*
  Charge cycle sequencer: picks trickle, pre-charge, CC, CV, top-off and
  done phases, runs safety and top-off timers, drives status pin and alert.
  Assumes analogue comparator and loop flags arrive asynchronously and are
  synchronised here; registers are reached over APB on clk.
*/
// Added by the designer: the APB register port and the address map.
`default_nettype none
module ccs_sequencer #(
  parameter int unsigned CELLS      = 2,
  parameter int unsigned TICK_CYC   = ccs_pkg::TICK_CYCLES,
  parameter int unsigned FAST_T     = ccs_pkg::FAST_TICKS,
  parameter int unsigned PRE_T      = ccs_pkg::PRECHG_TICKS,
  parameter int unsigned TRK_T      = ccs_pkg::TRICKLE_TICKS,
  parameter int unsigned TOPOFF_T   = ccs_pkg::TOPOFF_STEP_S
) (
  // Clock and reset
  input  wire  logic        clk,
  input  wire  logic        reset_n,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Analogue side, asynchronous
  input  wire  logic        chargeEnable_n,
  input  wire  logic        converterUp,
  input  wire  logic        thermFault,
  input  wire  logic        cvLoopActive,
  input  wire  logic        belowTermCurrent,
  input  wire  logic        inputCurrentLimitLoop,
  input  wire  logic        inputVoltageLimitLoop,
  input  wire  logic        thermalRegulationLoop,
  input  wire  logic        supplementMode,
  input  wire  logic [15:0] batteryMv,
  // Outputs
  output logic [2:0]        chargePhaseCode,
  output logic              hostAlert,
  output logic              statusPinOut,
  output logic              statusPinOe,
  output logic              batterySwitch,
  output logic              linearMode,
  output logic [15:0]       chargeCurrentMa,
  output logic              timerFault
);

  localparam int unsigned TW = 24;

  typedef enum logic [2:0] {ST_IDLE, ST_TRICKLE, ST_PRE, ST_CC, ST_CV, ST_TOPOFF,
                            ST_DONE, ST_FAULT} ccs_state_t;

  typedef struct packed {
    ccs_state_t  st;
    logic [9:0]  ctrl;
    logic [15:0] vregMv;
    logic [15:0] ichgMa;
    logic [8:0]  s1;
    logic [8:0]  s2;
    logic [15:0] vb1;
    logic [15:0] vb2;
    logic [25:0] tickCnt;
    logic        halfPhase;
    logic [TW-1:0] safety;
    logic [TW-1:0] topoff;
    logic [TW-1:0] topoffEnd;
    logic        termArm;
    logic        enPrev;
    logic        termPrev;
    logic        blink;
    logic [2:0]  code;
    logic        alert;
    logic [31:0] rdata;
  } ccs_reg_t;

  ccs_reg_t r;
  ccs_reg_t next_r;

  logic       sCe, sUp, sTherm, sCv, sLowI, sIlim, sVlim, sTreg, sSupp;
  logic       chgOn, limiting, tick, step, termHit, wr, rd;
  logic [15:0] rechgMv, lowvMv, vbat;
  logic [TW-1:0] limit;
  logic [2:0]  newCode;

  assign {sSupp, sTreg, sVlim, sIlim, sLowI, sCv, sTherm, sUp, sCe} = r.s2;
  assign vbat    = r.vb2;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !penable && !pwrite;
  assign chgOn   = r.ctrl[ccs_pkg::CTL_CHG_EN] && !sCe;
  assign limiting = sIlim || sVlim || sTreg;
  assign rechgMv = r.vregMv - (ccs_pkg::RECHG_BASE_MV
                   + 16'(r.ctrl[ccs_pkg::CTL_RECHG +: 2] - ccs_pkg::RECHG_SEL_RST)
                   * ccs_pkg::RECHG_STEP_MV);
  assign lowvMv  = 16'((32'(r.vregMv) * 32'd71) / 32'd100);
  assign tick    = r.tickCnt == 26'(TICK_CYC - 1);
  assign step    = tick && (!limiting || r.halfPhase);
  assign termHit = sLowI && (vbat > rechgMv) && sCv && !limiting;

  always_comb
  begin
    unique case (r.st)
      ST_TRICKLE: limit = TW'(TRK_T);
      ST_PRE:     limit = TW'(PRE_T);
      default:    limit = TW'(FAST_T);
    endcase
  end

  always_comb
  begin
    next_r = r;
    next_r.s1 = {supplementMode, thermalRegulationLoop, inputVoltageLimitLoop,
                 inputCurrentLimitLoop, belowTermCurrent, cvLoopActive, thermFault,
                 converterUp, chargeEnable_n};
    next_r.s2 = r.s1;
    next_r.vb1 = batteryMv;
    next_r.vb2 = r.vb1;
    next_r.alert = 1'b0;
    next_r.enPrev = chgOn;
    next_r.ctrl[ccs_pkg::CTL_RST] = 1'b0;
    next_r.tickCnt = tick ? 26'h0 : r.tickCnt + 26'h1;
    if (tick && limiting)
      next_r.halfPhase = !r.halfPhase;
    else if (!limiting)
      next_r.halfPhase = 1'b0;
    if (tick)
      next_r.blink = !r.blink;
    // Register writes
    if (wr)
    begin
      unique case (paddr)
        ccs_pkg::REG_CTRL:
        begin
          next_r.ctrl = pwdata[9:0];
          if (pwdata[ccs_pkg::CTL_TERM_EN] && !r.ctrl[ccs_pkg::CTL_TERM_EN])
            next_r.termArm = 1'b1;
          if (!pwdata[ccs_pkg::CTL_TERM_EN] && r.st != ST_TOPOFF && r.st != ST_DONE)
            next_r.termArm = 1'b0;
        end
        ccs_pkg::REG_CHARGE_VOLTAGE_TARGET: next_r.vregMv = pwdata[15:0];
        ccs_pkg::REG_FAST_CHARGE_CURRENT: next_r.ichgMa = pwdata[15:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      unique case (paddr)
        ccs_pkg::REG_CTRL:   next_r.rdata = {22'h0, r.ctrl};
        ccs_pkg::REG_STATUS: next_r.rdata = {27'h0, r.termArm, r.st == ST_FAULT, r.code};
        ccs_pkg::REG_CHARGE_VOLTAGE_TARGET:   next_r.rdata = {16'h0, r.vregMv};
        ccs_pkg::REG_FAST_CHARGE_CURRENT:   next_r.rdata = {16'h0, r.ichgMa};
        default:             next_r.rdata = 32'h0;
      endcase
    end
    // Sequencer
    if (!chgOn)
      next_r.st = ST_IDLE;
    else
    begin
      unique case (r.st)
        ST_IDLE:
          if (sUp && !sTherm)
          begin
            next_r.st = ST_TRICKLE;
            next_r.safety = '0;
            next_r.termArm = r.ctrl[ccs_pkg::CTL_TERM_EN];
          end
        ST_TRICKLE, ST_PRE, ST_CC, ST_CV:
        begin
          if (sTherm || !sUp || sSupp)
            next_r.safety = r.safety; // Suspended
          else if (step)
            next_r.safety = r.safety + TW'(1);
          if (r.safety >= limit)
            next_r.st = ST_FAULT;
          else if (r.st != ST_CV && vbat < ccs_pkg::TRICKLE_EXIT_MV)
          begin
            if (r.st != ST_TRICKLE) next_r.safety = '0;
            next_r.st = ST_TRICKLE;
          end
          else if (r.st != ST_CV && vbat < lowvMv)
          begin
            if (r.st != ST_PRE) next_r.safety = '0;
            next_r.st = ST_PRE;
          end
          else if (r.st == ST_CV || sCv)
          begin
            if (r.st != ST_CV && r.st != ST_CC) next_r.safety = '0;
            next_r.st = ST_CV;
            if (termHit && r.termArm)
            begin
              next_r.topoff = '0;
              next_r.topoffEnd = TW'(r.ctrl[ccs_pkg::CTL_TOPOFF +: 2]) * TW'(TOPOFF_T);
              next_r.st = (r.ctrl[ccs_pkg::CTL_TOPOFF +: 2] != 2'h0) ? ST_TOPOFF : ST_DONE;
            end
          end
          else
          begin
            if (r.st != ST_CC) next_r.safety = '0;
            next_r.st = ST_CC;
          end
        end
        ST_TOPOFF:
        begin
          if (!(sTherm || !sUp || sSupp) && step)
            next_r.topoff = r.topoff + TW'(1);
          if (r.topoff >= r.topoffEnd)
            next_r.st = ST_DONE;
        end
        ST_DONE:
          if (vbat < rechgMv)
          begin
            next_r.st = ST_IDLE;
            next_r.termArm = r.ctrl[ccs_pkg::CTL_TERM_EN];
          end
        ST_FAULT: ;
      endcase
    end
    if (chgOn && !r.enPrev)
      next_r.topoff = '0;
    if (r.ctrl[ccs_pkg::CTL_RST])
    begin
      next_r.topoff = '0;
      next_r.ctrl[ccs_pkg::CTL_TOPOFF +: 2] = 2'h0;
      if (r.st == ST_TOPOFF) next_r.st = ST_DONE;
    end
    unique case (next_r.st)
      ST_TRICKLE: newCode = ccs_pkg::PH_TRICKLE;
      ST_PRE:     newCode = ccs_pkg::PH_PRECHG;
      ST_CC:      newCode = ccs_pkg::PH_CC;
      ST_CV:      newCode = ccs_pkg::PH_CV;
      ST_TOPOFF:  newCode = ccs_pkg::PH_TOPOFF;
      ST_DONE:    newCode = ccs_pkg::PH_DONE;
      default:    newCode = ccs_pkg::PH_IDLE;
    endcase
    next_r.code = newCode;
    if (newCode != r.code && !r.ctrl[ccs_pkg::CTL_MASK])
      next_r.alert = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= ccs_pkg::CTL_RESET;
      r.vregMv <= 16'(ccs_pkg::CELL_CHARGE_VOLTAGE_TARGET_MV * 16'(CELLS));
      r.ichgMa <= (CELLS <= 2) ? ccs_pkg::FAST_LO_MA : ccs_pkg::FAST_HI_MA;
      r.s1 <= 9'h001;
      r.s2 <= 9'h001;
    end
    else
      r <= next_r;
  end

  assign prdata  = r.rdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign chargePhaseCode = r.code;
  assign hostAlert = r.alert;
  assign timerFault = r.st == ST_FAULT;
  assign statusPinOe = !r.ctrl[ccs_pkg::CTL_STAT_DIS];
  assign statusPinOut = (r.st == ST_FAULT) ? r.blink :
                        !(r.st inside {ST_TRICKLE, ST_PRE, ST_CC, ST_CV, ST_TOPOFF});
  assign batterySwitch = !(r.st == ST_DONE) || sSupp;
  assign linearMode = !r.ctrl[ccs_pkg::CTL_LDO_DIS] || r.st == ST_TRICKLE;
  always_comb
  begin
    unique case (r.st)
      ST_TRICKLE: chargeCurrentMa = ccs_pkg::TRICKLE_MA;
      ST_PRE:     chargeCurrentMa = ccs_pkg::PRECHG_MA;
      ST_CC, ST_CV, ST_TOPOFF: chargeCurrentMa = r.ichgMa;
      default:    chargeCurrentMa = 16'h0;
    endcase
  end

  // Assertions
  a_alert_on_change: assert property (@(posedge clk) disable iff (!reset_n)
    ($changed(chargePhaseCode) && !$past(r.ctrl[ccs_pkg::CTL_MASK])) |-> hostAlert)
    else $error("phase change without alert");
  a_idle_when_off: assert property (@(posedge clk) disable iff (!reset_n)
    !chgOn |=> chargePhaseCode == ccs_pkg::PH_IDLE)
    else $error("charging while disabled");
  a_done_switch_off: assert property (@(posedge clk) disable iff (!reset_n)
    (r.st == ST_DONE && !sSupp) |-> !batterySwitch)
    else $error("switch on after completion");
  a_no_term_limit: assert property (@(posedge clk) disable iff (!reset_n)
    (r.st == ST_CV && limiting) |=> r.st != ST_DONE && r.st != ST_TOPOFF)
    else $error("terminated while limiting");
  a_mask_alert: assert property (@(posedge clk) disable iff (!reset_n)
    $past(r.ctrl[ccs_pkg::CTL_MASK]) && r.ctrl[ccs_pkg::CTL_MASK] |-> !hostAlert)
    else $error("masked alert fired");
  a_stat_low_chg: assert property (@(posedge clk) disable iff (!reset_n)
    (r.st == ST_CC) |-> !statusPinOut)
    else $error("status pin not low while charging");
  a_topoff_code: assert property (@(posedge clk) disable iff (!reset_n)
    (r.st == ST_TOPOFF) |=> (chargePhaseCode == 3'h6 || chargePhaseCode == 3'h7
                             || chargePhaseCode == 3'h0))
    else $error("bad code in top-off");
  a_half_rate: assert property (@(posedge clk) disable iff (!reset_n)
    (tick && limiting && !r.halfPhase && r.st == ST_CC) |=> $stable(r.safety))
    else $error("timer advanced on skipped tick");

endmodule : ccs_sequencer
`default_nettype wire

// ===== test/ccs_battery_model.sv
/*
  Battery pack model for the charge cycle sequencer bench.
  Assumes the bench sets the pack voltage and whether the taper current is reached.
*/
`default_nettype none
module ccs_battery_model #(
  parameter int unsigned CHARGE_VOLTAGE_TARGET_MV = 8400
) (
  // Clock
  input  wire logic        clk,
  // Bench control
  input  wire logic [15:0] setMv,
  input  wire logic        full,
  // Charger side
  input  wire logic        batterySwitch,
  output logic [15:0]      batteryMv,
  output logic             cvLoopActive,
  output logic             belowTermCurrent
);
  timeunit 1ns;
  timeprecision 1ps;
  // CV loop only engages with the switch closed at target voltage
  always_ff @(posedge clk)
  begin
    batteryMv        <= setMv;
    cvLoopActive     <= batterySwitch && (setMv >= CHARGE_VOLTAGE_TARGET_MV[15:0]);
    belowTermCurrent <= batterySwitch && full && (setMv >= CHARGE_VOLTAGE_TARGET_MV[15:0]);
  end
endmodule : ccs_battery_model
`default_nettype wire

// ===== test/tb.sv
/*
  Self-checking bench for the charge cycle sequencer.
  Assumes APB with zero wait states and shortened timer parameters.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TCK = 4;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        chargeEnable_n = 1'b0;
  logic        converterUp = 1'b0;
  logic        limitOn = 1'b0;
  logic        vlimOn = 1'b0;
  logic        tregOn = 1'b0;
  logic        thermFault = 1'b0;
  logic        supplementMode = 1'b0;
  logic        pslverr;
  logic        linearMode;
  logic        full = 1'b0;
  logic [15:0] setMv = 16'h07D0;
  logic [15:0] batteryMv;
  logic        cvLoopActive;
  logic        belowTermCurrent;
  logic [2:0]  chargePhaseCode;
  logic [2:0]  prevCode = 3'h0;
  logic        hostAlert;
  logic        statusPinOut;
  logic        statusPinOe;
  logic        batterySwitch;
  logic [15:0] chargeCurrentMa;
  logic        timerFault;
  logic        maskOn = 1'b0;
  logic        a;
  logic [31:0] q;
  int          nMismatch = 0;
  int          totalChecks = 0;
  int          cyc = 0;

  always #12.5 clk = ~clk;

  ccs_sequencer #(.CELLS(2), .TICK_CYC(TCK), .FAST_T(20), .PRE_T(10), .TRK_T(5),
    .TOPOFF_T(3)) i_dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chargeEnable_n, .converterUp, .thermFault,
    .cvLoopActive, .belowTermCurrent, .inputCurrentLimitLoop(limitOn),
    .inputVoltageLimitLoop(vlimOn), .thermalRegulationLoop(tregOn), .supplementMode,
    .batteryMv, .chargePhaseCode, .hostAlert, .statusPinOut, .statusPinOe,
    .batterySwitch, .linearMode, .chargeCurrentMa, .timerFault);

  ccs_battery_model #(.CHARGE_VOLTAGE_TARGET_MV(8400)) i_bat (.clk, .setMv, .full, .batterySwitch,
    .batteryMv, .cvLoopActive, .belowTermCurrent);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic waitCode(input logic [2:0] exp, input int maxCyc);
    int n;
    n = 0;
    while (chargePhaseCode !== exp && n < maxCyc)
    begin
      @(negedge clk);
      n++;
    end
    chk({29'h0, chargePhaseCode}, {29'h0, exp});
    @(posedge clk);
  endtask : waitCode

  task automatic printVerdict;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : printVerdict

  // Alert pulse accompanies every phase code change unless masked
  always @(negedge clk)
  begin
    if (reset_n)
      chk({31'h0, hostAlert}, {31'h0, (chargePhaseCode !== prevCode) && !maskOn});
    prevCode = chargePhaseCode;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      nMismatch++;
      printVerdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h043);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'd8400);
    apb(1'b0, 8'h0C, 32'h0);
    chk(q, 32'd2000);
    apb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    repeat (6) @(posedge clk);
    chk({29'h0, chargePhaseCode}, 32'h0);
    converterUp <= 1'b1;
    thermFault  <= 1'b1;
    repeat (6) @(posedge clk);
    chk({29'h0, chargePhaseCode}, 32'h0);
    thermFault  <= 1'b0;
    waitCode(3'h1, 10);
    chk({16'h0, chargeCurrentMa}, 32'd100);
    chk({31'h0, linearMode}, 32'h1);
    chk({31'h0, statusPinOut}, 32'h0);
    setMv <= 16'd3000;
    waitCode(3'h2, 10);
    chk({16'h0, chargeCurrentMa}, 32'd120);
    setMv <= 16'd7000;
    waitCode(3'h3, 10);
    chk({16'h0, chargeCurrentMa}, 32'd2000);
    setMv <= 16'd8400;
    waitCode(3'h4, 10);
    limitOn <= 1'b1;
    full    <= 1'b1;
    repeat (4) @(posedge clk);
    limitOn <= 1'b0;
    vlimOn  <= 1'b1;
    repeat (4) @(posedge clk);
    vlimOn  <= 1'b0;
    tregOn  <= 1'b1;
    repeat (4) @(posedge clk);
    chk({29'h0, chargePhaseCode}, 32'h4);
    tregOn  <= 1'b0;
    waitCode(3'h7, 10);
    chk({31'h0, batterySwitch}, 32'h0);
    chk({31'h0, statusPinOut}, 32'h1);
    supplementMode <= 1'b1;
    repeat (4) @(negedge clk);
    chk({31'h0, batterySwitch}, 32'h1);
    supplementMode <= 1'b0;
    repeat (4) @(negedge clk);
    chk({31'h0, batterySwitch}, 32'h0);
    setMv <= 16'd8000;
    full  <= 1'b0;
    waitCode(3'h3, 10);
    apb(1'b1, 8'h00, 32'h14F);
    chk({31'h0, statusPinOe}, 32'h0);
    chk({31'h0, linearMode}, 32'h0);
    setMv <= 16'd8400;
    full  <= 1'b1;
    waitCode(3'h6, 20);
    chk({31'h0, batterySwitch}, 32'h1);
    waitCode(3'h7, 30);
    chargeEnable_n <= 1'b1;
    waitCode(3'h0, 10);
    chargeEnable_n <= 1'b0;
    full  <= 1'b0;
    setMv <= 16'd8000;
    waitCode(3'h3, 10);
    apb(1'b1, 8'h00, 32'h041);
    setMv <= 16'd8400;
    full  <= 1'b1;
    waitCode(3'h4, 10);
    repeat (20) @(posedge clk);
    chk({29'h0, chargePhaseCode}, 32'h4);
    apb(1'b1, 8'h00, 32'h043);
    waitCode(3'h7, 10);
    apb(1'b1, 8'h00, 32'h053);
    maskOn = 1'b1;
    apb(1'b1, 8'h00, 32'h052);
    waitCode(3'h0, 10);
    apb(1'b1, 8'h00, 32'h053);
    waitCode(3'h7, 30);
    apb(1'b1, 8'h00, 32'h043);
    maskOn = 1'b0;
    setMv <= 16'd2000;
    full  <= 1'b0;
    waitCode(3'h1, 10);
    repeat (40) @(negedge clk);
    chk({31'h0, timerFault}, 32'h1);
    a = statusPinOut;
    repeat (TCK) @(negedge clk);
    chk({31'h0, statusPinOut}, {31'h0, !a});
    printVerdict();
  end
endmodule : tb
`default_nettype wire
